// ==== pkg/ptm_cfg.svh ====
`ifndef PTM_CFG_SVH
`define PTM_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PTM_OFF_CTRL0 12'h000
`define PTM_OFF_CTRL1 12'h004
`define PTM_OFF_CMPA_LO 12'h008
`define PTM_OFF_CMPA_HI 12'h00c
`define PTM_OFF_PER_LO 12'h010
`define PTM_OFF_PER_HI 12'h014
`define PTM_OFF_STATUS 12'h018

// ----------------------------------------
// field positions
// ----------------------------------------
`define PTM_CTRL0_RUN 0
`define PTM_CTRL1_MODE_LO 6
`define PTM_CTRL1_ACT_LO 4
`define PTM_CTRL1_INIT 3
`define PTM_CTRL1_INV 2
`define PTM_CTRL1_CLRSEL 0
`define PTM_STAT_FLAG_A 0
`define PTM_STAT_FLAG_P 1
`define PTM_STAT_OUT 2

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define PTM_RST_CTRL0 8'h00
`define PTM_RST_CTRL1 8'h00
`define PTM_RST_CMP 10'h000
`define PTM_CNT_MAX 10'h3ff
`define PTM_CNT_ONE 10'h001

`endif

// ==== pkg/ptm_pkg.sv ====
package ptm_pkg;

    // ----------------------------------------
    // modes and output actions
    // ----------------------------------------
    typedef enum logic [1:0] {
        PTM_MODE_CMP = 2'h0,
        PTM_MODE_CAP = 2'h1,
        PTM_MODE_PWM = 2'h2,
        PTM_MODE_TMR = 2'h3
    } ptm_mode_t;

    typedef enum logic [1:0] {
        PTM_ACT_NONE = 2'h0,
        PTM_ACT_LOW = 2'h1,
        PTM_ACT_HIGH = 2'h2,
        PTM_ACT_TOG = 2'h3
    } ptm_act_t;

    // ----------------------------------------
    // register index from address decode
    // ----------------------------------------
    typedef enum logic [2:0] {
        PTM_REG_CTRL0 = 3'h0,
        PTM_REG_CTRL1 = 3'h1,
        PTM_REG_CMPA_LO = 3'h2,
        PTM_REG_CMPA_HI = 3'h3,
        PTM_REG_PER_LO = 3'h4,
        PTM_REG_PER_HI = 3'h5,
        PTM_REG_STATUS = 3'h6,
        PTM_REG_NONE = 3'h7
    } ptm_reg_t;

    // ----------------------------------------
    // whole state of the timer top except the reset release flops
    // ----------------------------------------
    typedef struct packed {
        logic run;
        logic run_prev;
        logic pin_prev;
        ptm_mode_t mode;
        ptm_act_t act;
        logic init;
        logic inv;
        logic clr_sel;
        logic [9:0] cmp_a;
        logic [9:0] per;
        logic [9:0] cnt;
        logic flag_a;
        logic flag_p;
        logic out;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic pin_o;
        logic pin_oe;
    } ptm_state_t;

endpackage

// ==== rtl/ptm_cmp.sv ====
`timescale 1ns/1ps
`include "ptm_cfg.svh"

module ptm_cmp (
    // counter and compare values
    input logic [9:0] cnt,
    input logic [9:0] per,
    input logic [9:0] cmp_a,
    // match results
    output logic p_hit,
    output logic a_hit,
    output logic duty_on
);

    // ----------------------------------------
    // comparators
    // ----------------------------------------
    // period zero wraps to the full count
    assign p_hit = (cnt == per - `PTM_CNT_ONE);
    // compare value zero never matches
    assign a_hit = (cmp_a != `PTM_RST_CMP) && (cnt == cmp_a - `PTM_CNT_ONE);
    assign duty_on = ((per != `PTM_RST_CMP) && (cmp_a >= per)) || (cnt < cmp_a);

endmodule

// ==== rtl/ptm_top.sv ====
`timescale 1ns/1ps
`include "ptm_cfg.svh"

// Summary of operation
// - mode 00: compare-match output, counts while running
// - clear-select low: clear on P, both flags
// - clear-select high: clear on A, no P flag
// - compare A zero: wrap at 3FF, no A flag
// - output changes only on A match or run rise
// - action field: high, low, toggle, or none
// - run rising edge loads initial output level
// - mode 11: same as compare, pin undriven
// - mode 10: period clears counter, A sets duty
// - period 1..1023 counts, zero gives 1024
// - duty at or above period: 100 percent
// - PWM raises A and P flags on matches, no P flag in single pulse
// - action forces or enables PWM; level, invert
// - PWM counting continues with action 00 or 01
// - mode 10 with action 11: single pulse
// - run rise or pin edge starts pulse
// - A match or run clear ends pulse
// - single pulse: counter zeroed on run rise
// - period value split low byte, two high bits
// - invert bit flips output in modes 00 and 10 only, not in capture or timer mode
module ptm_top (
    // clock and reset
    input logic clk,
    input logic rst_b,
    // apb slave
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // pins
    input logic ext_clk_pin,
    output logic timer_out,
    output logic timer_out_oe
);

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_meta_b_q;
    logic rst_b_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b_q <= 1'b0;
            rst_b_q <= 1'b0;
        end else begin
            rst_meta_b_q <= 1'b1;
            rst_b_q <= rst_meta_b_q;
        end
    end

    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic ptm_pkg::ptm_reg_t reg_idx(input logic [11:0] a);
        case (a)
            `PTM_OFF_CTRL0: reg_idx = ptm_pkg::PTM_REG_CTRL0;
            `PTM_OFF_CTRL1: reg_idx = ptm_pkg::PTM_REG_CTRL1;
            `PTM_OFF_CMPA_LO: reg_idx = ptm_pkg::PTM_REG_CMPA_LO;
            `PTM_OFF_CMPA_HI: reg_idx = ptm_pkg::PTM_REG_CMPA_HI;
            `PTM_OFF_PER_LO: reg_idx = ptm_pkg::PTM_REG_PER_LO;
            `PTM_OFF_PER_HI: reg_idx = ptm_pkg::PTM_REG_PER_HI;
            `PTM_OFF_STATUS: reg_idx = ptm_pkg::PTM_REG_STATUS;
            default: reg_idx = ptm_pkg::PTM_REG_NONE;
        endcase
    endfunction

    ptm_pkg::ptm_state_t s_q;
    ptm_pkg::ptm_state_t s_d;
    ptm_pkg::ptm_reg_t sel;
    logic p_hit;
    logic a_hit;
    logic duty_on;
    logic acc_wr;
    logic run_rise;
    logic ext_rise;
    logic cmp_like;
    logic single;
    logic evt_a;
    logic evt_p;

    ptm_cmp u_cmp (
        .cnt(s_q.cnt),
        .per(s_q.per),
        .cmp_a(s_q.cmp_a),
        .p_hit(p_hit),
        .a_hit(a_hit),
        .duty_on(duty_on)
    );

    assign sel = reg_idx(paddr);
    assign acc_wr = psel & penable & s_q.pready & pwrite;
    assign run_rise = s_q.run & ~s_q.run_prev;
    assign ext_rise = ext_clk_pin & ~s_q.pin_prev;
    assign cmp_like = (s_q.mode == ptm_pkg::PTM_MODE_CMP) || (s_q.mode == ptm_pkg::PTM_MODE_TMR);
    assign single = (s_q.mode == ptm_pkg::PTM_MODE_PWM) && (s_q.act == ptm_pkg::PTM_ACT_TOG);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.run_prev = s_q.run;
        s_d.pin_prev = ext_clk_pin;
        // match events
        // stale count at pulse start must not end the pulse
        evt_a = s_q.run && a_hit && (s_q.mode != ptm_pkg::PTM_MODE_CAP)
            && !(single && run_rise);
        evt_p = s_q.run && p_hit && !single && (s_q.mode != ptm_pkg::PTM_MODE_CAP)
            && !(cmp_like && s_q.clr_sel);
        // apb answer, one wait state
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        if (psel && penable && !s_q.pready) begin
            s_d.pready = 1'b1;
            s_d.pslverr = (sel == ptm_pkg::PTM_REG_NONE);
            s_d.prdata = 32'h0000_0000;
            if (!pwrite) begin
                case (sel)
                    ptm_pkg::PTM_REG_CTRL0: s_d.prdata[`PTM_CTRL0_RUN] = s_q.run;
                    ptm_pkg::PTM_REG_CTRL1: s_d.prdata[7:0] =
                        {s_q.mode, s_q.act, s_q.init, s_q.inv, 1'b0, s_q.clr_sel};
                    ptm_pkg::PTM_REG_CMPA_LO: s_d.prdata[7:0] = s_q.cmp_a[7:0];
                    ptm_pkg::PTM_REG_CMPA_HI: s_d.prdata[1:0] = s_q.cmp_a[9:8];
                    ptm_pkg::PTM_REG_PER_LO: s_d.prdata[7:0] = s_q.per[7:0];
                    ptm_pkg::PTM_REG_PER_HI: s_d.prdata[1:0] = s_q.per[9:8];
                    ptm_pkg::PTM_REG_STATUS: s_d.prdata[2:0] = {s_q.out, s_q.flag_p, s_q.flag_a};
                    default: s_d.prdata = 32'h0000_0000;
                endcase
            end
        end
        // register writes
        if (acc_wr) begin
            case (sel)
                ptm_pkg::PTM_REG_CTRL0: s_d.run = pwdata[`PTM_CTRL0_RUN];
                ptm_pkg::PTM_REG_CTRL1: begin
                    s_d.mode = ptm_pkg::ptm_mode_t'(pwdata[`PTM_CTRL1_MODE_LO +: 2]);
                    s_d.act = ptm_pkg::ptm_act_t'(pwdata[`PTM_CTRL1_ACT_LO +: 2]);
                    s_d.init = pwdata[`PTM_CTRL1_INIT];
                    s_d.inv = pwdata[`PTM_CTRL1_INV];
                    s_d.clr_sel = pwdata[`PTM_CTRL1_CLRSEL];
                end
                ptm_pkg::PTM_REG_CMPA_LO: s_d.cmp_a[7:0] = pwdata[7:0];
                ptm_pkg::PTM_REG_CMPA_HI: s_d.cmp_a[9:8] = pwdata[1:0];
                ptm_pkg::PTM_REG_PER_LO: s_d.per[7:0] = pwdata[7:0];
                ptm_pkg::PTM_REG_PER_HI: s_d.per[9:8] = pwdata[1:0];
                ptm_pkg::PTM_REG_STATUS: begin
                    s_d.flag_a = s_q.flag_a & ~pwdata[`PTM_STAT_FLAG_A];
                    s_d.flag_p = s_q.flag_p & ~pwdata[`PTM_STAT_FLAG_P];
                end
                default: s_d.run = s_q.run;
            endcase
        end
        // flags, set wins over clear
        if (evt_a) begin
            s_d.flag_a = 1'b1;
        end
        if (evt_p) begin
            s_d.flag_p = 1'b1;
        end
        // counter
        if (single) begin
            if (run_rise) begin
                s_d.cnt = `PTM_RST_CMP;
            end else if (s_q.run) begin
                s_d.cnt = s_q.cnt + `PTM_CNT_ONE;
            end
            if (evt_a) begin
                s_d.run = 1'b0;
            end
            if (ext_rise) begin
                s_d.run = 1'b1;
            end
        end else if (s_q.run) begin
            if (cmp_like && s_q.clr_sel) begin
                // compare zero never hits, so counter wraps past max
                s_d.cnt = a_hit ? `PTM_RST_CMP : s_q.cnt + `PTM_CNT_ONE;
            end else begin
                s_d.cnt = p_hit ? `PTM_RST_CMP : s_q.cnt + `PTM_CNT_ONE;
            end
        end
        // output level
        if (cmp_like) begin
            if (run_rise) begin
                s_d.out = s_q.init;
            end else if (evt_a) begin
                case (s_q.act)
                    ptm_pkg::PTM_ACT_LOW: s_d.out = 1'b0;
                    ptm_pkg::PTM_ACT_HIGH: s_d.out = 1'b1;
                    ptm_pkg::PTM_ACT_TOG: s_d.out = ~s_q.out;
                    default: s_d.out = s_q.out;
                endcase
            end
        end else if (single) begin
            // active from the edge that zeroes the counter, so width equals compare A
            s_d.out = s_d.run && s_q.run;
        end else if (s_q.mode == ptm_pkg::PTM_MODE_PWM) begin
            case (s_q.act)
                ptm_pkg::PTM_ACT_LOW: s_d.out = 1'b1;
                ptm_pkg::PTM_ACT_HIGH: s_d.out = s_q.run && duty_on;
                default: s_d.out = 1'b0;
            endcase
        end
        // pin from next state
        case (s_d.mode)
            ptm_pkg::PTM_MODE_CMP: begin
                s_d.pin_o = s_d.out ^ s_d.inv;
                s_d.pin_oe = 1'b1;
            end
            ptm_pkg::PTM_MODE_PWM: begin
                s_d.pin_o = (s_d.out ? s_d.init : ~s_d.init) ^ s_d.inv;
                s_d.pin_oe = 1'b1;
            end
            default: begin
                s_d.pin_o = 1'b0;
                s_d.pin_oe = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pready = s_q.pready;
    assign prdata = s_q.prdata;
    assign pslverr = s_q.pslverr;
    assign timer_out = s_q.pin_o;
    assign timer_out_oe = s_q.pin_oe;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b_q);

    p_clear_a: assert property (
        (cmp_like && !s_q.clr_sel && s_q.run && s_q.cnt == s_q.per - `PTM_CNT_ONE)
        |=> (s_q.cnt == 10'h000) && s_q.flag_p)
        else $error("period match did not clear counter or set flag");

    a_clear_a: assert property (
        (cmp_like && s_q.clr_sel && s_q.run && s_q.cmp_a != 10'h000
        && s_q.cnt == s_q.cmp_a - `PTM_CNT_ONE) |=> (s_q.cnt == 10'h000) && s_q.flag_a)
        else $error("compare A match did not clear counter");

    no_p_flag_a: assert property (
        (cmp_like && s_q.clr_sel && !s_q.flag_p && !acc_wr) |=> !s_q.flag_p)
        else $error("period flag raised with clear on A");

    wrap_max_a: assert property (
        (cmp_like && s_q.clr_sel && s_q.run && s_q.cmp_a == 10'h000 && !s_q.flag_a
        && s_q.cnt == `PTM_CNT_MAX && !acc_wr) |=> (s_q.cnt == 10'h000) && !s_q.flag_a)
        else $error("counter did not wrap or A flag raised");

    out_hold_a: assert property (
        (s_q.mode == ptm_pkg::PTM_MODE_CMP && !run_rise && !evt_a && !acc_wr)
        |=> $stable(timer_out))
        else $error("output changed without A match");

    out_high_a: assert property (
        (s_q.mode == ptm_pkg::PTM_MODE_CMP && !run_rise && evt_a
        && s_q.act == ptm_pkg::PTM_ACT_HIGH && !acc_wr) |=> timer_out == ~s_q.inv)
        else $error("go-high action not applied");

    run_init_a: assert property (
        (s_q.mode == ptm_pkg::PTM_MODE_CMP && run_rise && !acc_wr)
        |=> timer_out == (s_q.init ^ s_q.inv))
        else $error("initial level not loaded on run");

    tmr_pin_a: assert property (
        (s_q.mode == ptm_pkg::PTM_MODE_TMR && !acc_wr) |=> !timer_out_oe && !timer_out)
        else $error("pin driven in timer mode");

    pwm_period_a: assert property (
        (s_q.mode == ptm_pkg::PTM_MODE_PWM && !single && s_q.run
        && s_q.cnt == s_q.per - `PTM_CNT_ONE) |=> s_q.cnt == 10'h000)
        else $error("PWM period wrong");

    pwm_full_a: assert property (
        (s_q.mode == ptm_pkg::PTM_MODE_PWM && s_q.act == ptm_pkg::PTM_ACT_HIGH && s_q.run
        && s_q.per != 10'h000 && s_q.cmp_a >= s_q.per && !acc_wr)
        |=> timer_out == (s_q.init ^ s_q.inv))
        else $error("full duty not held");

    sp_trig_a: assert property (
        (single && ext_rise) |=> s_q.run ##1 (timer_out == (s_q.init ^ s_q.inv)))
        else $error("pin edge did not start pulse");

    sp_end_a: assert property (
        (single && evt_a && !ext_rise && !acc_wr)
        |=> !s_q.run && s_q.flag_a && timer_out == (~s_q.init ^ s_q.inv))
        else $error("A match did not end pulse");

    sp_zero_a: assert property (
        (single && run_rise) |=> s_q.cnt == 10'h000)
        else $error("counter not zeroed at pulse start");

endmodule

// ==== verification/ptm_pin_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// pin side: trigger source and pulse meter
// ----------------------------------------
module ptm_pin_model (
    // clock
    input wire logic clk,
    // timer pins
    input wire logic timer_out,
    output logic ext_clk_pin,
    // measured pulse figures in cycles
    output int hi_width,
    output int period,
    output int rises
);
    int cyc = 0;
    int t_rise = 0;
    logic prev = 1'b0;

    initial begin
        ext_clk_pin = 1'b0;
        hi_width = 0;
        period = 0;
        rises = 0;
    end

    task automatic trigger();
        @(posedge clk);
        ext_clk_pin <= 1'b1;
        @(posedge clk);
        ext_clk_pin <= 1'b0;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        prev <= timer_out;
        if (timer_out === 1'b1 && prev === 1'b0) begin
            period <= cyc - t_rise;
            t_rise <= cyc;
            rises <= rises + 1;
        end
        if (timer_out === 1'b0 && prev === 1'b1) begin
            hi_width <= cyc - t_rise;
        end
    end
endmodule

// ==== verification/test_periodic_timer_modes.sv ====
`timescale 1ns/1ps
`include "ptm_cfg.svh"

module test_periodic_timer_modes;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic ext_clk_pin;
    logic timer_out;
    logic timer_out_oe;
    int hi_width;
    int period;
    int rises;
    int r0;
    int failures = 0;
    int checks_done = 0;
    integer seed = 32'h11cf;
    logic [32:0] exq[$];
    logic [32:0] mkq[$];
    logic [32:0] e;
    logic [32:0] m;
    logic [9:0] duty;

    always #50 clk = ~clk;

    ptm_top u_ptm_top (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .ext_clk_pin(ext_clk_pin),
        .timer_out(timer_out), .timer_out_oe(timer_out_oe));

    ptm_pin_model u_ptm_pin_model (.clk(clk), .timer_out(timer_out),
        .ext_clk_pin(ext_clk_pin), .hi_width(hi_width), .period(period), .rises(rises));

    // ----------------------------------------
    // compare, verdict and bus tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            n = n + 1;
            if (n > 20) begin
                failures = failures + 1;
                tally_and_finish();
            end
            @(posedge clk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] x, input logic [32:0] k);
        exq.push_back(x);
        mkq.push_back(k);
        apb(a, 1'b0, 32'h0);
    endtask

    function automatic logic [31:0] ctl(input int md, input int act, input int ini,
        input int inv, input int clr);
        ctl = (md << `PTM_CTRL1_MODE_LO) | (act << `PTM_CTRL1_ACT_LO)
            | (ini << `PTM_CTRL1_INIT) | (inv << `PTM_CTRL1_INV) | clr;
    endfunction

    task automatic setup(input logic [31:0] c, input logic [9:0] a, input logic [9:0] p,
        input logic run);
        wr(`PTM_OFF_CTRL0, 32'h0);
        wr(`PTM_OFF_CTRL1, c);
        wr(`PTM_OFF_CMPA_LO, {24'h0, a[7:0]});
        wr(`PTM_OFF_CMPA_HI, {30'h0, a[9:8]});
        wr(`PTM_OFF_PER_LO, {24'h0, p[7:0]});
        wr(`PTM_OFF_PER_HI, {30'h0, p[9:8]});
        wr(`PTM_OFF_STATUS, 32'h3);
        wr(`PTM_OFF_CTRL0, {31'h0, run});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // ----------------------------------------
    // read data monitor
    // ----------------------------------------
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = exq.pop_front();
            m = mkq.pop_front();
            check("prdata", {pslverr, prdata} & m, e);
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        settle(3);
        rd(`PTM_OFF_PER_LO, 33'h0, 33'h1ffffffff);
        rd(`PTM_OFF_PER_HI, 33'h0, 33'h1ffffffff);
        rd(`PTM_OFF_CTRL1, 33'h0, 33'h1ffffffff);
        wr(`PTM_OFF_PER_HI, 32'hff);
        rd(`PTM_OFF_PER_HI, 33'h3, 33'h1ffffffff);
        wr(`PTM_OFF_PER_LO, 32'ha5);
        rd(`PTM_OFF_PER_LO, 33'ha5, 33'h1ffffffff);
        rd(12'h01c, 33'h100000000, 33'h1ffffffff);
        duty = 10'(2 + ($random(seed) & 32'h7));
        setup(ctl(0, 3, 0, 0, 0), duty, 10'd12, 1'b1);
        settle(1100);
        check("hi width", 33'(hi_width), 33'd12);
        check("period", 33'(period), 33'd24);
        rd(`PTM_OFF_STATUS, 33'h3, 33'h3);
        setup(ctl(0, 3, 0, 0, 1), 10'd8, 10'd3, 1'b1);
        settle(1100);
        check("hi width", 33'(hi_width), 33'd8);
        rd(`PTM_OFF_STATUS, 33'h1, 33'h3);
        // overflow by period zero, then wrap by compare A zero
        for (int c = 0; c < 2; c++) begin
            setup(ctl(0, 3, 1, 0, c), 10'd0, 10'd0, 1'b1);
            settle(5);
            r0 = rises;
            settle(1100);
            check("rises", 33'(rises), 33'(r0));
            rd(`PTM_OFF_STATUS, 33'h4, (c == 0) ? 33'h5 : 33'h7);
        end
        for (int i = 0; i < 3; i++) begin
            setup(ctl(0, i, (i == 2) ? 0 : 1, 0, 0), 10'd4, 10'd10, 1'b1);
            settle(1100);
            rd(`PTM_OFF_STATUS, (i != 1) ? 33'h4 : 33'h0, 33'h4);
        end
        setup(ctl(3, 3, 1, 1, 0), 10'd3, 10'd6, 1'b1);
        settle(1100);
        check("oe", 33'(timer_out_oe), 33'h0);
        check("pin", 33'(timer_out), 33'h0);
        rd(`PTM_OFF_STATUS, 33'h3, 33'h3);
        duty = 10'(1 + ($random(seed) & 32'h3));
        setup(ctl(2, 2, 1, 0, 1), duty, 10'd8, 1'b1);
        settle(1100);
        check("hi width", 33'(hi_width), 33'(duty));
        check("period", 33'(period), 33'd8);
        check("oe", 33'(timer_out_oe), 33'h1);
        rd(`PTM_OFF_STATUS, 33'h3, 33'h3);
        setup(ctl(2, 2, 1, 1, 0), duty, 10'd8, 1'b1);
        settle(1100);
        check("hi width", 33'(hi_width), 33'(8 - duty));
        setup(ctl(2, 2, 1, 0, 0), 10'd9, 10'd8, 1'b1);
        settle(1100);
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            check("pin", 33'(timer_out), 33'h1);
        end
        setup(ctl(2, 2, 1, 0, 0), 10'd100, 10'd0, 1'b1);
        settle(2200);
        check("period", 33'(period), 33'd1024);
        check("hi width", 33'(hi_width), 33'd100);
        for (int i = 1; i >= 0; i--) begin
            setup(ctl(2, i, 1, 0, 0), 10'd3, 10'd8, 1'b1);
            settle(1100);
            check("pin", 33'(timer_out), 33'(i));
            rd(`PTM_OFF_STATUS, 33'h3, 33'h3);
        end
        setup(ctl(2, 3, 1, 0, 0), 10'd6, 10'd0, 1'b0);
        r0 = rises;
        u_ptm_pin_model.trigger();
        settle(30);
        check("rises", 33'(rises), 33'(r0 + 1));
        check("hi width", 33'(hi_width), 33'd6);
        rd(`PTM_OFF_CTRL0, 33'h0, 33'h1);
        rd(`PTM_OFF_STATUS, 33'h1, 33'h1);
        wr(`PTM_OFF_CTRL0, 32'h1);
        settle(100);
        check("rises", 33'(rises), 33'(r0 + 2));
        check("hi width", 33'(hi_width), 33'd6);
        setup(ctl(2, 3, 1, 0, 0), 10'd300, 10'd0, 1'b1);
        settle(20);
        check("pin", 33'(timer_out), 33'h1);
        wr(`PTM_OFF_CTRL0, 32'h0);
        settle(3);
        check("pin", 33'(timer_out), 33'h0);
        settle(5);
        tally_and_finish();
    end
endmodule
